// *** logic/dual_aux_pwm_timers.sv ***
// Purpose: two 8-bit auxiliary pulse-width generators behind APB
// Assumes: single clock pclk, async active-low reset presetn
// Notes: zero-wait APB slave; unmapped addresses answer pslverr

module dual_aux_pwm_timers
  import aux_pwm_pkg::*;
#(
  parameter int unsigned W = PWM_W
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // output pins
  output logic secondary_pwm_out_a,
  output logic secondary_pwm_out_b
);

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  initial begin
    if (W != 8) $error("register map needs W of 8");
    if (ADDR_W < 5) begin
      $error("address too narrow for the register map");
    end
    if (MODE_INDEP_BIT < 8 || MODE_INDEP_BIT > 15) begin
      $error("mode bit must sit in byte lane 1");
    end
    if (TICK_DIV != 2) begin
      $error("time base must be two clocks");
    end
  end

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------

  // register index from address, 7 when unmapped
  function automatic logic [2:0] reg_index(
    input logic [ADDR_W-1:0] addr
  );
    logic [2:0] idx;
    idx = 3'h7;
    case (addr)
      OFS_A_PERIOD: idx = 3'h0;
      OFS_B_PERIOD: idx = 3'h1;
      OFS_A_ON: idx = 3'h2;
      OFS_B_ON: idx = 3'h3;
      OFS_MODE: idx = 3'h4;
      OFS_ENABLE: idx = 3'h5;
      OFS_STATUS: idx = 3'h6;
      default: idx = 3'h7;
    endcase
    return idx;
  endfunction

  // write strobe for one register, qualified by its byte lane
  function automatic logic lane_write(
    input logic wr_cycle,
    input logic [2:0] hit,
    input logic [2:0] want,
    input logic lane
  );
    return wr_cycle && (hit == want) && lane;
  endfunction

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [W-1:0] pwm_a_period;
  logic [W-1:0] pwm_b_period_or_offset;
  logic [W-1:0] pwm_a_on_time;
  logic [W-1:0] pwm_b_on_time;
  logic mode_indep;
  logic [1:0] pin_enable;

  logic access;
  logic wr;
  logic [2:0] idx;
  logic low_lane;
  logic high_lane;
  logic wr_a_period;
  logic wr_b_period;
  logic wr_mode;
  logic restart;
  logic wr_a_on;
  logic wr_b_on;
  logic wr_enable;
  logic next_mode_indep;

  logic tick;
  logic a_level;
  logic b_level;
  logic a_running;
  logic b_running;
  logic [W-1:0] a_count;
  logic [W-1:0] b_count;
  logic [W-1:0] b_period_eff;
  logic start_a;
  logic start_b;
  logic stop_b;
  logic sync_b;

  logic [31:0] next_prdata;

  // ----------------------------------------
  // apb access decode
  // ----------------------------------------

  // zero wait; a frozen block stalls the bus
  assign pready = ce;
  assign access = psel && penable && ce;
  assign wr = access && pwrite;
  assign idx = reg_index(paddr);
  assign low_lane = pstrb[0];
  assign high_lane = pstrb[1];
  // status is read-only: writes there are dropped without error
  assign pslverr = access && (idx == 3'h7);

  // period writes and mode changes restart timing
  assign wr_a_period = lane_write(wr, idx, 3'h0, low_lane);
  assign wr_b_period = lane_write(wr, idx, 3'h1, low_lane);
  assign wr_mode = lane_write(wr, idx, 3'h4, high_lane);
  assign restart = wr_a_period || wr_b_period || wr_mode;

  // on-time and pin enable writes, no restart
  assign wr_a_on = lane_write(wr, idx, 3'h2, low_lane);
  assign wr_b_on = lane_write(wr, idx, 3'h3, low_lane);
  assign wr_enable = lane_write(wr, idx, 3'h5, low_lane);

  // mode as it stands after this edge, so a mode write
  // restarts B under the mode it selects
  assign next_mode_indep = wr_mode ? pwdata[MODE_INDEP_BIT] : mode_indep;

  // ----------------------------------------
  // period registers
  // ----------------------------------------

  // any 8-bit value is taken as written
  // the same write restarts A through restart; B restarts too in independent mode, in offset mode it stops until sync
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_a_period <= PERIOD_RST;
      pwm_b_period_or_offset <= PERIOD_RST;
    end else if (ce) begin
      if (wr_a_period) begin
        pwm_a_period <= pwdata[W-1:0];
      end
      if (wr_b_period) begin
        pwm_b_period_or_offset <= pwdata[W-1:0];
      end
    end
  end

  // ----------------------------------------
  // on-time registers
  // ----------------------------------------

  // stored now, latched by the generator at cycle start
  // so a mid-cycle write never cuts the running pulse short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_a_on_time <= ON_RST;
      pwm_b_on_time <= ON_RST;
    end else if (ce) begin
      if (wr_a_on) begin
        pwm_a_on_time <= pwdata[W-1:0];
      end
      if (wr_b_on) begin
        pwm_b_on_time <= pwdata[W-1:0];
      end
    end
  end

  // ----------------------------------------
  // mode and pin enable registers
  // ----------------------------------------

  // mode bit 8 lives in byte lane 1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_indep <= MODE_INDEP_RST;
    end else if (ce && wr_mode) begin
      mode_indep <= pwdata[MODE_INDEP_BIT];
    end
  end

  // per-pin enables, bit 0 for A, bit 1 for B
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_enable <= ENABLE_RST;
    end else if (ce && wr_enable) begin
      pin_enable <= pwdata[1:0];
    end
  end

  // ----------------------------------------
  // tick generation
  // ----------------------------------------

  // one tick per two clocks, realigned on restart
  pwm_tick_divider #(
    .DIV(TICK_DIV)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .clear(restart),
    .tick(tick)
  );

  // ----------------------------------------
  // mode steering
  // ----------------------------------------

  // offset mode: B shares A period
  assign b_period_eff = mode_indep ? pwm_b_period_or_offset : pwm_a_period;

  // B starts when A count reaches the offset value
  // an offset above A's period never syncs, B then stays low
  assign sync_b = !mode_indep && tick && a_running
    && (a_count == pwm_b_period_or_offset);

  // restart: A always begins; B waits for sync in offset mode
  assign start_a = restart;
  assign start_b = (restart && next_mode_indep) || (!restart && sync_b);
  assign stop_b = restart && !next_mode_indep;

  // ----------------------------------------
  // generators
  // ----------------------------------------

  // generator A
  pwm_channel #(
    .W(W)
  ) u_chan_a (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .tick(tick),
    .start(start_a),
    .stop(1'b0),
    .period(pwm_a_period),
    .on_time(pwm_a_on_time),
    .level(a_level),
    .running(a_running),
    .count(a_count)
  );

  // generator B
  pwm_channel #(
    .W(W)
  ) u_chan_b (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .tick(tick),
    .start(start_b),
    .stop(stop_b),
    .period(b_period_eff),
    .on_time(pwm_b_on_time),
    .level(b_level),
    .running(b_running),
    .count(b_count)
  );

  // ----------------------------------------
  // output pins
  // ----------------------------------------

  // registered pins, low while disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      secondary_pwm_out_a <= 1'b0;
      secondary_pwm_out_b <= 1'b0;
    end else if (ce) begin
      secondary_pwm_out_a <= a_level && pin_enable[0];
      secondary_pwm_out_b <= b_level && pin_enable[1];
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------

  // read mux, status shows live generator state
  always_comb begin
    next_prdata = 32'h0000_0000;
    case (idx)
      3'h0: next_prdata = {24'h00_0000, pwm_a_period};
      3'h1: next_prdata = {24'h00_0000, pwm_b_period_or_offset};
      3'h2: next_prdata = {24'h00_0000, pwm_a_on_time};
      3'h3: next_prdata = {24'h00_0000, pwm_b_on_time};
      3'h4: next_prdata = {23'h00_0000, mode_indep, 8'h00};
      3'h5: next_prdata = {30'h0000_0000, pin_enable};
      3'h6: begin
        next_prdata = {8'h00, b_count, a_count,
          4'h0, b_running, a_running, b_level, a_level};
      end
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // read data from the setup cycle onward
  // captured in setup so the access phase sees settled data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      if (psel && !penable && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

endmodule

// *** logic/aux_pwm_pkg.sv ***
// Purpose: shared constants for the dual auxiliary pulse-width timers
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: offsets are byte addresses

package aux_pwm_pkg;

  // ----------------------------------------
  // widths and timing
  // ----------------------------------------
  localparam int unsigned PWM_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned TICK_DIV = 2;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_A_PERIOD = 8'h00;
  localparam logic [7:0] OFS_B_PERIOD = 8'h04;
  localparam logic [7:0] OFS_A_ON = 8'h08;
  localparam logic [7:0] OFS_B_ON = 8'h0C;
  localparam logic [7:0] OFS_MODE = 8'h10;
  localparam logic [7:0] OFS_ENABLE = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int unsigned MODE_INDEP_BIT = 8;
  localparam logic [7:0] PERIOD_RST = 8'hFF;
  localparam logic [7:0] ON_RST = 8'h00;
  localparam logic MODE_INDEP_RST = 1'b0;
  localparam logic [1:0] ENABLE_RST = 2'h0;

  // ----------------------------------------
  // generator state
  // ----------------------------------------
  typedef enum logic {
    CH_IDLE = 1'b0,
    CH_RUN = 1'b1
  } ch_state_e;

endpackage

// *** logic/pwm_tick_divider.sv ***
// Purpose: one-cycle tick every DIV clock cycles
// Assumes: clear restarts the count from zero
// Notes: frozen while ce is low

module pwm_tick_divider
  import aux_pwm_pkg::*;
#(
  parameter int unsigned DIV = TICK_DIV
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // control
  input wire logic clear,
  output logic tick
);

  initial begin
    if (DIV < 1 || DIV > 255) $error("DIV out of range");
  end

  logic [7:0] count;

  // tick on the last count of each group
  assign tick = ce && !clear && (count == 8'(DIV - 1));

  // count, restart on clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 8'h00;
    end else if (ce) begin
      if (clear || tick) begin
        count <= 8'h00;
      end else begin
        count <= count + 8'h01;
      end
    end
  end

endmodule

// *** logic/pwm_channel.sv ***
// Purpose: one pulse-width generator counting in divided ticks
// Assumes: start and stop are single-cycle strobes
// Notes: level is combinational; the top registers it

module pwm_channel
  import aux_pwm_pkg::*;
#(
  parameter int unsigned W = PWM_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // timing
  input wire logic tick,
  input wire logic start,
  input wire logic stop,
  input wire logic [W-1:0] period,
  input wire logic [W-1:0] on_time,
  // state out
  output logic level,
  output logic running,
  output logic [W-1:0] count
);

  initial begin
    if (W < 2 || W > 16) $error("W out of range");
  end

  ch_state_e state;
  logic [W-1:0] on_act;

  assign running = (state == CH_RUN);
  // high from cycle start until on-time elapses; on above period stays high
  assign level = running && (count < on_act);

  // counter, cycle wrap and on-time latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= CH_RUN;
      count <= '0;
      on_act <= '0;
    end else if (ce) begin
      if (start) begin
        state <= CH_RUN;
        count <= '0;
        on_act <= on_time;
      end else if (stop) begin
        state <= CH_IDLE;
        count <= '0;
      end else if (tick && running) begin
        if (count >= period) begin
          count <= '0;
          on_act <= on_time;
        end else begin
          count <= count + W'(1);
        end
      end
    end
  end

endmodule

// *** testbench/pwm_port_chk.sv ***
// Purpose: port checker for the pwm timers
// Assumes: one clock, async active-low reset
// Notes: bound to the top module
module pwm_port_chk
  import aux_pwm_pkg::*;
(
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic secondary_pwm_out_a,
  input wire logic secondary_pwm_out_b
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic acc;
  logic bad;
  // ----
  // access decode
  // ----
  assign acc = psel && penable;
  assign bad = (paddr > OFS_STATUS) || (paddr[1:0] != 2'h0);
  a_ready_tracks_ce: assert property (pready == ce)
    else $error("pready not equal to ce");
  a_bad_addr_err: assert property (acc && bad |-> pslverr)
    else $error("unmapped access without error");
  a_good_addr_ok: assert property (acc && !bad |-> !pslverr)
    else $error("mapped access answered with error");
  a_err_only_access: assert property (!acc |-> !pslverr)
    else $error("error outside access phase");
  a_bad_read_zero: assert property (acc && !pwrite && bad |-> prdata == 32'h0)
    else $error("unmapped read data not zero");
  a_reg_width_8: assert property (acc && !pwrite && paddr < OFS_MODE
    |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_rdata_holds: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved outside read setup");
  a_freeze_pins: assert property (!ce ##1 !ce |=>
    $stable(secondary_pwm_out_a) && $stable(secondary_pwm_out_b))
    else $error("pins moved while frozen");
endmodule
bind dual_aux_pwm_timers pwm_port_chk u_chk (.pclk(pclk), .presetn(presetn), .ce(ce),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .secondary_pwm_out_a(secondary_pwm_out_a),
  .secondary_pwm_out_b(secondary_pwm_out_b));

// *** testbench/pwm_pin_load.sv ***
// Purpose: load model timing one pwm pin
// Assumes: pin levels sampled at rising edges
// Notes: passive, never drives the pin
module pwm_pin_load (
  // clock and pins
  input wire logic pclk,
  input wire logic pin,
  input wire logic ref_pin,
  // measurement
  input wire logic arm,
  output logic done = 1'b0,
  output logic [15:0] hi_len,
  output logic [15:0] per_len,
  output logic [15:0] lag_len
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] now = 16'h0;
  logic [15:0] t_rise, t_fall, t_ref;
  logic p_d = 1'b0;
  logic r_d = 1'b0;
  logic seen = 1'b0;
  // ----
  // edge timing
  // ----
  // second rise after arm closes one full cycle
  always @(posedge pclk) begin
    done <= 1'b0;
    now <= now + 16'h1;
    p_d <= pin;
    r_d <= ref_pin;
    if (ref_pin && !r_d) t_ref <= now;
    if (!pin && p_d) t_fall <= now;
    if (pin && !p_d) begin
      t_rise <= now;
      seen <= arm && !seen;
      if (arm && seen) begin
        done <= 1'b1;
        hi_len <= t_fall - t_rise;
        per_len <= now - t_rise;
        lag_len <= now - t_ref;
      end
    end else if (!arm) seen <= 1'b0;
  end
endmodule

// *** testbench/dual_aux_pwm_timers_tb_top.sv ***
// Purpose: self-checking bench for the pwm timers
// Assumes: zero-wait apb slave, registered pins
// Notes: pin timing measured by the load models
module dual_aux_pwm_timers_tb_top import aux_pwm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn, ce, psel, penable, pwrite, arm, pready, pslverr, out_a, out_b, done_a, done_b;
  logic [7:0] paddr, pa, oa, pb, ob;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [15:0] hi_a, per_a, hi_b, per_b, lag_b;
  logic [32:0] rq[$];
  logic [31:0] qa[$];
  logic [48:0] qb[$];
  logic [48:0] eb;
  int errors = 0;
  int tests_run = 0;
  int n_done = 0;
  always #25 pclk = ~pclk;
  dual_aux_pwm_timers DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .secondary_pwm_out_a(out_a),
    .secondary_pwm_out_b(out_b));
  pwm_pin_load u_load_a (.pclk(pclk), .pin(out_a), .ref_pin(out_b), .arm(arm),
    .done(done_a), .hi_len(hi_a), .per_len(per_a), .lag_len());
  pwm_pin_load u_load_b (.pclk(pclk), .pin(out_b), .ref_pin(out_a), .arm(arm),
    .done(done_b), .hi_len(hi_b), .per_len(per_b), .lag_len(lag_b));
  // ----
  // tasks
  // ----
  task automatic check(input string nm, input logic [32:0] e, input logic [32:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    check("apb_ready", 33'h1, {32'h0, pready});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0, 4'h0);
  endtask
  task automatic wait_a(input logic v);
    int n;
    n = 0;
    while (out_a !== v && n < 600) begin
      @(posedge pclk);
      n++;
    end
    check("wait_a", 33'(v), 33'(out_a));
  endtask
  // expected high time and period in cycles
  function automatic logic [31:0] hp(input logic [7:0] on, input logic [7:0] p);
    return {7'h0, on, 1'b0, 7'h0, p, 1'b0} + 32'h2;
  endfunction
  task automatic meas(input logic [31:0] ea, input logic [48:0] e2);
    int n;
    n = n_done + 2;
    qa.push_back(ea);
    qb.push_back(e2);
    arm <= 1'b1;
    repeat (3000) if (n_done < n) @(posedge pclk);
    check("meas_done", 33'(n), 33'(n_done));
    qa.delete();
    qb.delete();
    arm <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----
  // result watcher
  // ----
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && rq.size() > 0)
      check("rdata", rq.pop_front(), {pslverr, prdata});
    if (done_a && qa.size() > 0) begin
      check("pin_a", 33'(qa.pop_front()), {1'b0, hi_a, per_a});
      n_done++;
    end
    if (done_b && qb.size() > 0) begin
      eb = qb.pop_front();
      check("pin_b", 33'(eb[31:0]), {1'b0, hi_b, per_b});
      if (eb[48]) check("lag_b", 33'(eb[47:32]), 33'(lag_b));
      n_done++;
    end
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    give_verdict();
  end
  // ----
  // main sequence
  // ----
  initial begin
    void'($urandom(32'hE4A4));
    {presetn, psel, penable, pwrite, arm, paddr, pwdata, pstrb} = '0;
    ce = 1'b1;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFS_A_PERIOD, 33'hFF);
    rd(OFS_B_PERIOD, 33'hFF);
    rd(OFS_A_ON, 33'h0);
    rd(OFS_B_ON, 33'h0);
    rd(OFS_MODE, 33'h0);
    rd(8'h1C, 33'h100000000);
    rd(8'h02, 33'h100000000);
    wr(OFS_ENABLE, 32'h3);
    wr(OFS_MODE, 32'h100);
    for (int i = 0; i < 3; i++) begin
      pa = (i == 0) ? 8'h01 : (i == 1) ? 8'hFF : 8'($urandom_range(40, 2));
      oa = 8'($urandom_range(pa, 1));
      pb = 8'($urandom_range(30, 2));
      ob = 8'($urandom_range(pb, 1));
      wr(OFS_A_ON, {24'h0, oa});
      wr(OFS_B_ON, {24'h0, ob});
      wr(OFS_B_PERIOD, {24'h0, pb});
      wr(OFS_A_PERIOD, {24'h0, pa});
      rd(OFS_A_PERIOD, {25'h0, pa});
      meas(hp(oa, pa), {17'h0, hp(ob, pb)});
    end
    wr(OFS_A_ON, 32'h0);
    wr(OFS_B_ON, 32'h5);
    wr(OFS_B_PERIOD, 32'h0);
    wr(OFS_A_PERIOD, 32'h3);
    repeat (4) @(posedge pclk);
    for (int j = 0; j < 12; j++) begin
      @(posedge pclk);
      check("zero_duty", 33'h0, {32'h0, out_a});
      check("full_duty", 33'h1, {32'h0, out_b});
    end
    wr(OFS_A_ON, 32'hA);
    wr(OFS_B_ON, 32'h3);
    wr(OFS_B_PERIOD, 32'h5);
    wr(OFS_A_PERIOD, 32'h14);
    wait_a(1'b0);
    wait_a(1'b1);
    wr(OFS_A_ON, 32'h2);
    repeat (8) @(posedge pclk);
    check("old_on", 33'h1, {32'h0, out_a});
    meas(hp(8'h2, 8'h14), {17'h0, hp(8'h3, 8'h5)});
    wait_a(1'b1);
    wait_a(1'b0);
    wr(OFS_A_PERIOD, 32'h14);
    repeat (2) @(posedge pclk);
    check("restart", 33'h1, {32'h0, out_a});
    wr(OFS_MODE, 32'h0);
    wr(OFS_A_ON, 32'h5);
    wr(OFS_B_PERIOD, 32'h6);
    wr(OFS_A_PERIOD, 32'h14);
    meas(hp(8'h5, 8'h14), {1'b1, 16'h000E, hp(8'h3, 8'h14)});
    apb(1'b1, OFS_A_ON, 32'h7, 4'hE);
    rd(OFS_A_ON, 33'h5);
    ce <= 1'b0;
    repeat (6) @(posedge pclk);
    ce <= 1'b1;
    repeat (4) @(posedge pclk);
    give_verdict();
  end
endmodule
